// ### hw/dc2_caps_reg.v
`include "dc2_map.vh"

module dc2_caps_reg #(
  parameter [11:0] CAP_BASE      = 12'h070,  // Capability base byte offset
  parameter [1:0]  MAX_PREFIXES  = 2'h0,     // Max end-end prefixes field
  parameter [0:0]  EE_PREFIX     = 1'h0,     // End-end prefix accepted
  parameter [0:0]  EXT_FMT       = 1'h0,     // Three-bit format supported
  parameter [1:0]  OBFF_LEVEL    = 2'h0,     // Flush/fill support level
  parameter [1:0]  TPH_LEVEL     = 2'h0,     // Completer hint level
  parameter [0:0]  LTR_SUPPORT   = 1'h0,     // Latency tolerance supported
  parameter [0:0]  CAS128        = 1'h0,     // 128-bit swap completer
  parameter [0:0]  ATOMIC64      = 1'h0,     // 64-bit atomic completer
  parameter [0:0]  ATOMIC32      = 1'h0,     // 32-bit atomic completer
  parameter [3:0]  CTO_RANGES    = 4'h0      // Timeout ranges supported
) (
  // Clock, reset and enable
  input  wire        i_core_clk,
  input  wire        i_rstn,
  input  wire        i_ce,
  // Configuration access port
  input  wire        i_cfg_rd,
  input  wire        i_cfg_wr,
  input  wire [11:0] i_cfg_addr,
  input  wire [3:0]  i_cfg_be,
  input  wire [31:0] i_cfg_wdata,
  // Configuration answer
  output wire        o_cfg_ack,
  output wire [31:0] o_cfg_rdata,
  // Capabilities toward the function's own logic
  output wire        o_ee_prefix_en,
  output wire        o_atomic32_en,
  output wire        o_atomic64_en,
  output wire        o_cas128_en,
  output wire        o_ltr_en,
  output wire [1:0]  o_tph_level,
  output wire        o_cto_disable_capable
);

  // Address of the word within configuration space
  localparam [11:0] WORD_ADDR = CAP_BASE + `DC2_OFS_DEVCAP2;

  // Field values held in flops
  wire [1:0] max_pfx_val;    // Max prefixes
  wire [0:0] ee_prefix_val;  // End-end prefix support
  wire [0:0] ext_fmt_val;    // Format width support
  wire [1:0] obff_val;       // Flush/fill level
  wire [1:0] tph_val;        // Completer hint level
  wire [0:0] ltr_val;        // Latency tolerance
  wire [0:0] cas128_val;     // Wide swap completer
  wire [0:0] at64_val;       // 64-bit atomics
  wire [0:0] at32_val;       // 32-bit atomics
  wire [3:0] cto_rng_val;    // Timeout ranges

  // Assembled register word
  wire [31:0] cap_word;

  // Access decode
  wire        addr_hit;      // Dword address matches
  wire [31:0] lane_mask;     // Byte enables widened to bits

  // Answer flops
  reg         ack_ff;
  reg  [31:0] rdata_ff;
  reg         nxt_ack;
  reg  [31:0] nxt_rdata;

  // Capability output flops
  reg         ee_prefix_ff;
  reg         atomic32_ff;
  reg         atomic64_ff;
  reg         cas128_ff;
  reg         ltr_ff;
  reg  [1:0]  tph_ff;
  reg         cto_dis_ff;

  // Implementation-fixed fields, one holder each
  dc2_ro_field #(.W(2), .VALUE(MAX_PREFIXES)) u_max_pfx (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .o_value    (max_pfx_val)
  );

  dc2_ro_field #(.W(1), .VALUE(EE_PREFIX)) u_ee_prefix (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .o_value    (ee_prefix_val)
  );

  dc2_ro_field #(.W(1), .VALUE(EXT_FMT)) u_ext_fmt (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .o_value    (ext_fmt_val)
  );

  dc2_ro_field #(.W(2), .VALUE(OBFF_LEVEL)) u_obff (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .o_value    (obff_val)
  );

  // Reserved hint code would mislead software, so show none instead
  dc2_ro_field #(
    .W        (2),
    .VALUE    (TPH_LEVEL),
    .RSVD_EN  (1),
    .RSVD_VAL (`DC2_TPH_RSVD),
    .REPL_VAL (`DC2_TPH_NONE)
  ) u_tph (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .o_value    (tph_val)
  );

  dc2_ro_field #(.W(1), .VALUE(LTR_SUPPORT)) u_ltr (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .o_value    (ltr_val)
  );

  dc2_ro_field #(.W(1), .VALUE(CAS128)) u_cas128 (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .o_value    (cas128_val)
  );

  dc2_ro_field #(.W(1), .VALUE(ATOMIC64)) u_at64 (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .o_value    (at64_val)
  );

  dc2_ro_field #(.W(1), .VALUE(ATOMIC32)) u_at32 (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .o_value    (at32_val)
  );

  dc2_ro_field #(.W(4), .VALUE(CTO_RANGES)) u_cto_rng (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .o_value    (cto_rng_val)
  );

  // Word assembly; reserved spans read as zero
  assign cap_word[`DC2_POS_RSVD_HI_MSB:`DC2_POS_RSVD_HI_LSB]   = `DC2_RSVD_ZERO8;
  assign cap_word[`DC2_POS_MAX_PFX_MSB:`DC2_POS_MAX_PFX_LSB]   = max_pfx_val;
  assign cap_word[`DC2_POS_EE_PREFIX]                          = ee_prefix_val[0];
  assign cap_word[`DC2_POS_EXT_FMT]                            = ext_fmt_val[0];
  assign cap_word[`DC2_POS_OBFF_MSB:`DC2_POS_OBFF_LSB]         = obff_val;
  assign cap_word[`DC2_POS_RSVD_MID_MSB:`DC2_POS_RSVD_MID_LSB] = `DC2_RSVD_ZERO4;
  assign cap_word[`DC2_POS_TPH_MSB:`DC2_POS_TPH_LSB]           = tph_val;
  assign cap_word[`DC2_POS_LTR]                                = ltr_val[0];
  assign cap_word[`DC2_POS_RLX_PASS]                           = `DC2_HW_RLX_PASS;
  assign cap_word[`DC2_POS_CAS128]                             = cas128_val[0];
  assign cap_word[`DC2_POS_AT64]                               = at64_val[0];
  assign cap_word[`DC2_POS_AT32]                               = at32_val[0];
  assign cap_word[`DC2_POS_AT_ROUTE]                           = `DC2_HW_AT_ROUTE;
  assign cap_word[`DC2_POS_ARI_FWD]                            = `DC2_HW_ARI_FWD;
  // Always advertised: a self-requesting endpoint needs the disable
  assign cap_word[`DC2_POS_CTO_DIS]                            = `DC2_HW_CTO_DIS;
  assign cap_word[`DC2_POS_CTO_RNG_MSB:`DC2_POS_CTO_RNG_LSB]   = cto_rng_val;

  // Dword decode ignores the two byte-select bits
  assign addr_hit  = (i_cfg_addr[11:2] == WORD_ADDR[11:2]);
  assign lane_mask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};

  // Answer next-state: reads return masked word, writes only acked
  always @* begin
    nxt_ack   = 1'b0;
    nxt_rdata = `DC2_RST_WORD;
    if (addr_hit && i_cfg_rd) begin
      // Read wins if both strobes are raised together
      nxt_ack   = 1'b1;
      nxt_rdata = cap_word & lane_mask;
    end else if (addr_hit && i_cfg_wr) begin
      // Write data dropped on purpose; nothing here is writable
      nxt_ack   = 1'b1;
      nxt_rdata = `DC2_RST_WORD;
    end else begin
      // Other addresses belong to neighbouring registers
      nxt_ack   = 1'b0;
      nxt_rdata = `DC2_RST_WORD;
    end
  end

  // Answer flops, frozen while the enable is low
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_ff   <= 1'b0;
      rdata_ff <= `DC2_RST_WORD;
    end else if (i_ce) begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // Capability flops feeding the function's datapath
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ee_prefix_ff <= 1'b0;
      atomic32_ff  <= 1'b0;
      atomic64_ff  <= 1'b0;
      cas128_ff    <= 1'b0;
      ltr_ff       <= 1'b0;
      tph_ff       <= `DC2_TPH_NONE;
      cto_dis_ff   <= 1'b0;
    end else if (i_ce) begin
      ee_prefix_ff <= ee_prefix_val[0];
      atomic32_ff  <= at32_val[0];
      atomic64_ff  <= at64_val[0];
      cas128_ff    <= cas128_val[0];
      ltr_ff       <= ltr_val[0];
      tph_ff       <= tph_val;
      // Tells the requester engine its timeout may be switched off
      cto_dis_ff   <= `DC2_HW_CTO_DIS;
    end
  end

  // Outputs straight from flops
  assign o_cfg_ack             = ack_ff;
  assign o_cfg_rdata           = rdata_ff;
  assign o_ee_prefix_en        = ee_prefix_ff;
  assign o_atomic32_en         = atomic32_ff;
  assign o_atomic64_en         = atomic64_ff;
  assign o_cas128_en           = cas128_ff;
  assign o_ltr_en              = ltr_ff;
  assign o_tph_level           = tph_ff;
  assign o_cto_disable_capable = cto_dis_ff;

  // Write data is never looked at
  wire unused_wdata = &{1'b0, i_cfg_wdata};

endmodule

// ### hw/dc2_map.vh
`ifndef DC2_MAP_VH
`define DC2_MAP_VH

// Byte offset of the capabilities-two word from the capability base
`define DC2_OFS_DEVCAP2      12'h024

// Field positions inside the capabilities-two word
`define DC2_POS_RSVD_HI_MSB  31
`define DC2_POS_RSVD_HI_LSB  24
`define DC2_POS_MAX_PFX_MSB  23
`define DC2_POS_MAX_PFX_LSB  22
`define DC2_POS_EE_PREFIX    21
`define DC2_POS_EXT_FMT      20
`define DC2_POS_OBFF_MSB     19
`define DC2_POS_OBFF_LSB     18
`define DC2_POS_RSVD_MID_MSB 17
`define DC2_POS_RSVD_MID_LSB 14
`define DC2_POS_TPH_MSB      13
`define DC2_POS_TPH_LSB      12
`define DC2_POS_LTR          11
`define DC2_POS_RLX_PASS     10
`define DC2_POS_CAS128       9
`define DC2_POS_AT64         8
`define DC2_POS_AT32         7
`define DC2_POS_AT_ROUTE     6
`define DC2_POS_ARI_FWD      5
`define DC2_POS_CTO_DIS      4
`define DC2_POS_CTO_RNG_MSB  3
`define DC2_POS_CTO_RNG_LSB  0

// Hardwired and reset values
`define DC2_RST_WORD         32'h0000_0000
`define DC2_HW_RLX_PASS      1'h0
`define DC2_HW_AT_ROUTE      1'h0
`define DC2_HW_ARI_FWD       1'h0
`define DC2_HW_CTO_DIS       1'h1
`define DC2_RSVD_ZERO4       4'h0
`define DC2_RSVD_ZERO8       8'h00

// Completer-hint encodings
`define DC2_TPH_NONE         2'h0
`define DC2_TPH_ONLY         2'h1
`define DC2_TPH_RSVD         2'h2
`define DC2_TPH_BOTH         2'h3

// Read answer latency in core cycles
`define DC2_RD_LAT           1

`endif

// ### hw/dc2_ro_field.v
// Read-only field holder: loads its implementation value at reset
// and never changes afterwards. A reserved encoding is swapped for
// a safe one so software can never see an illegal code.
module dc2_ro_field #(
  parameter          W        = 1,
  parameter [W-1:0]  VALUE    = {W{1'b0}},
  parameter          RSVD_EN  = 0,
  parameter [W-1:0]  RSVD_VAL = {W{1'b0}},
  parameter [W-1:0]  REPL_VAL = {W{1'b0}}
) (
  // Clock and reset
  input  wire         i_core_clk,
  input  wire         i_rstn,
  // Field value
  output wire [W-1:0] o_value
);

  // Legal value chosen at elaboration
  localparam [W-1:0] LEGAL = (RSVD_EN != 0 && VALUE == RSVD_VAL) ? REPL_VAL : VALUE;

  reg [W-1:0] value_ff;   // Holds the constant

  // Constant load under reset, hold otherwise
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      value_ff <= LEGAL;
    end else begin
      value_ff <= value_ff;
    end
  end

  assign o_value = value_ff;

endmodule

// ### bench/dc2_caps_reg_sva.sv
module dc2_caps_reg_sva #(
  parameter [11:0] CAP_BASE     = 12'h070,
  parameter [1:0]  MAX_PREFIXES = 2'h0,
  parameter [0:0]  EE_PREFIX    = 1'h0,
  parameter [0:0]  EXT_FMT      = 1'h0,
  parameter [1:0]  OBFF_LEVEL   = 2'h0,
  parameter [1:0]  TPH_LEVEL    = 2'h0,
  parameter [0:0]  LTR_SUPPORT  = 1'h0,
  parameter [0:0]  CAS128       = 1'h0,
  parameter [0:0]  ATOMIC64     = 1'h0,
  parameter [0:0]  ATOMIC32     = 1'h0,
  parameter [3:0]  CTO_RANGES   = 4'h0
) (
  // Watched ports
  input wire logic        i_core_clk,
  input wire logic        i_rstn,
  input wire logic        i_ce,
  input wire logic        i_cfg_rd,
  input wire logic        i_cfg_wr,
  input wire logic [11:0] i_cfg_addr,
  input wire logic [3:0]  i_cfg_be,
  input wire logic        o_cfg_ack,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic        o_ee_prefix_en,
  input wire logic        o_atomic32_en,
  input wire logic        o_atomic64_en,
  input wire logic        o_cas128_en,
  input wire logic        o_ltr_en,
  input wire logic [1:0]  o_tph_level,
  input wire logic        o_cto_disable_capable
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam [11:0] HIT  = CAP_BASE + 12'h024;  // Word address
  // Reserved hint code never shown, so it is folded to none
  localparam [1:0]  TPH  = (TPH_LEVEL == 2'h2) ? 2'h0 : TPH_LEVEL;
  localparam [31:0] WORD = {8'h00, MAX_PREFIXES, EE_PREFIX, EXT_FMT, OBFF_LEVEL, 4'h0,
                            TPH, LTR_SUPPORT, 1'b0, CAS128, ATOMIC64, ATOMIC32, 3'b001, CTO_RANGES};
  wire        hit   = (i_cfg_rd | i_cfg_wr) & (i_cfg_addr[11:2] == HIT[11:2]);
  wire [31:0] bmask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // Request taken, read taken, and outputs past their load edge
  sequence s_take; i_ce && hit; endsequence
  sequence s_take_rd; s_take ##0 i_cfg_rd; endsequence
  sequence s_settled; $past(i_rstn) && $past(i_ce); endsequence
  ack_on_hit_a: assert property (s_take |=> o_cfg_ack) else $error("no ack on hit");
  no_ack_miss_a: assert property (i_ce && !hit |=> !o_cfg_ack) else $error("ack on miss");
  read_word_a: assert property (s_take_rd |=> o_cfg_rdata == (WORD & $past(bmask)))
    else $error("read word wrong");
  write_keep_a: assert property (s_take ##0 !i_cfg_rd |=> o_cfg_rdata == 32'h0000_0000)
    else $error("write returned data");
  idle_zero_a: assert property (!o_cfg_ack |-> o_cfg_rdata == 32'h0000_0000)
    else $error("data without ack");
  ce_hold_a: assert property (!i_ce |=> $stable(o_cfg_ack) && $stable(o_cfg_rdata))
    else $error("moved while disabled");
  caps_out_a: assert property (s_settled |-> {o_ee_prefix_en, o_atomic32_en, o_atomic64_en,
    o_cas128_en, o_ltr_en, o_tph_level} == {EE_PREFIX, ATOMIC32, ATOMIC64, CAS128, LTR_SUPPORT, TPH})
    else $error("capability outputs wrong");
  hint_legal_a: assert property (o_tph_level != 2'h2) else $error("reserved hint code");
  cto_cap_a: assert property (s_settled |-> o_cto_disable_capable)
    else $error("timeout disable missing");
endmodule

bind dc2_caps_reg dc2_caps_reg_sva #(.CAP_BASE(CAP_BASE), .MAX_PREFIXES(MAX_PREFIXES),
  .EE_PREFIX(EE_PREFIX), .EXT_FMT(EXT_FMT), .OBFF_LEVEL(OBFF_LEVEL), .TPH_LEVEL(TPH_LEVEL),
  .LTR_SUPPORT(LTR_SUPPORT), .CAS128(CAS128), .ATOMIC64(ATOMIC64), .ATOMIC32(ATOMIC32),
  .CTO_RANGES(CTO_RANGES)) u_sva (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(i_ce),
  .i_cfg_rd(i_cfg_rd), .i_cfg_wr(i_cfg_wr), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
  .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata), .o_ee_prefix_en(o_ee_prefix_en),
  .o_atomic32_en(o_atomic32_en), .o_atomic64_en(o_atomic64_en), .o_cas128_en(o_cas128_en),
  .o_ltr_en(o_ltr_en), .o_tph_level(o_tph_level), .o_cto_disable_capable(o_cto_disable_capable));

// ### bench/tb_dc2_caps_reg.sv
module tb_dc2_caps_reg;
  timeunit 1ns;
  timeprecision 1ps;
  // Field values picked so most bits of the word are exercised
  localparam [11:0] P_ADDR = 12'h094;  // Base 0x070 plus 0x024
  localparam [1:0]  P_MAXP = 2'h1;
  localparam [1:0]  P_OBFF = 2'h2;
  localparam [1:0]  P_TPH  = 2'h1;
  localparam [3:0]  P_CTO  = 4'hb;
  localparam [31:0] EXP    = {8'h00, P_MAXP, 2'b11, P_OBFF, 4'h0, P_TPH,
                              2'b10, 3'b101, 3'b001, P_CTO};
  logic        i_core_clk  = 1'b0;
  logic        i_rstn      = 1'b0;
  logic        i_ce        = 1'b0;
  logic        i_cfg_rd    = 1'b0;
  logic        i_cfg_wr    = 1'b0;
  logic [11:0] i_cfg_addr  = 12'h000;
  logic [3:0]  i_cfg_be    = 4'h0;
  logic [31:0] i_cfg_wdata = 32'h0000_0000;
  wire         o_cfg_ack, o_ee_prefix_en, o_atomic32_en, o_atomic64_en;
  wire         o_cas128_en, o_ltr_en, o_cto_disable_capable;
  wire  [31:0] o_cfg_rdata;
  wire  [1:0]  o_tph_level;
  int          fail_count  = 0;
  int          check_count = 0;
  int          cycles      = 0;

  dc2_caps_reg #(.MAX_PREFIXES(P_MAXP), .EE_PREFIX(1'h1), .EXT_FMT(1'h1), .OBFF_LEVEL(P_OBFF),
    .TPH_LEVEL(P_TPH), .LTR_SUPPORT(1'h1), .CAS128(1'h1), .ATOMIC64(1'h0), .ATOMIC32(1'h1),
    .CTO_RANGES(P_CTO)) DUT (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_cfg_rd(i_cfg_rd), .i_cfg_wr(i_cfg_wr), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
    .i_cfg_wdata(i_cfg_wdata), .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata),
    .o_ee_prefix_en(o_ee_prefix_en), .o_atomic32_en(o_atomic32_en),
    .o_atomic64_en(o_atomic64_en), .o_cas128_en(o_cas128_en), .o_ltr_en(o_ltr_en),
    .o_tph_level(o_tph_level), .o_cto_disable_capable(o_cto_disable_capable));

  // 250 MHz core clock
  initial forever #2 i_core_clk = ~i_core_clk;

  // Hang guard: the whole run needs well under a hundred cycles
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count = fail_count + 1;
      $display("MISMATCH t=%0t timeout", $time);
      summarize();
    end
  end

  // Value compare; flags arrive zero-extended
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count = check_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One request, then settle past the answer edge
  task cfg(input logic rd, input logic wr, input logic [11:0] a, input logic [3:0] be);
    @(posedge i_core_clk);
    i_cfg_rd    <= rd;
    i_cfg_wr    <= wr;
    i_cfg_addr  <= a;
    i_cfg_be    <= be;
    i_cfg_wdata <= 32'hffff_ffff;
    @(posedge i_core_clk);
    i_cfg_rd <= 1'b0;
    i_cfg_wr <= 1'b0;
    #1;
  endtask

  task t_caps;
    chk(o_ee_prefix_en, 1'b1, "prefix");
    chk({o_atomic32_en, o_atomic64_en, o_cas128_en}, 3'b101, "atomics");
    chk(o_ltr_en, 1'b1, "latency");
    chk(o_tph_level, P_TPH, "hint");
    chk(o_cto_disable_capable, 1'b1, "timeout disable");
    $display("t_caps done");
  endtask

  task t_read;
    cfg(1'b1, 1'b0, P_ADDR, 4'hf);
    chk(o_cfg_ack, 1'b1, "read ack");
    chk(o_cfg_rdata, EXP, "word");
    @(posedge i_core_clk);
    #1;
    chk({o_cfg_ack, o_cfg_rdata}, 33'h0, "answer one cycle");
    // Single lanes, with the ignored low address bits equal to the lane index
    for (int i = 0; i < 4; i++) begin
      cfg(1'b1, 1'b0, P_ADDR + 12'(i), 4'(1 << i));
      chk(o_cfg_rdata, EXP & (32'h0000_00ff << (8 * i)), "lane");
    end
    $display("t_read done");
  endtask

  // Write directly followed by read, then both strobes at once
  task t_write;
    @(posedge i_core_clk);
    i_cfg_wr   <= 1'b1;
    i_cfg_addr <= P_ADDR;
    i_cfg_be   <= 4'hf;
    @(posedge i_core_clk);
    i_cfg_wr <= 1'b0;
    i_cfg_rd <= 1'b1;
    #1;
    chk({o_cfg_ack, o_cfg_rdata}, {1'b1, 32'h0000_0000}, "write answer");
    @(posedge i_core_clk);
    i_cfg_rd <= 1'b0;
    #1;
    chk(o_cfg_rdata, EXP, "after write");
    cfg(1'b1, 1'b1, P_ADDR, 4'hf);
    chk(o_cfg_rdata, EXP, "read with write");
    $display("t_write done");
  endtask

  // Neighbour words get no answer
  task t_miss;
    cfg(1'b1, 1'b0, P_ADDR + 12'h004, 4'hf);
    chk({o_cfg_ack, o_cfg_rdata}, 33'h0, "miss above");
    cfg(1'b1, 1'b0, P_ADDR - 12'h004, 4'hf);
    chk({o_cfg_ack, o_cfg_rdata}, 33'h0, "miss below");
    $display("t_miss done");
  endtask

  // Disabled clock freezes the answer
  task t_ce;
    cfg(1'b1, 1'b0, P_ADDR, 4'hf);
    i_ce <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    #1;
    chk({o_cfg_ack, o_cfg_rdata}, {1'b1, EXP}, "frozen answer");
    @(posedge i_core_clk);
    i_ce <= 1'b1;
    @(posedge i_core_clk);
    #1;
    chk(o_cfg_ack, 1'b0, "ack released");
    $display("t_ce done");
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    i_ce   <= 1'b1;
    @(posedge i_core_clk);
    #1;
    t_caps();
    t_read();
    t_write();
    t_miss();
    t_ce();
    summarize();
  end
endmodule
